// ==== hw/dtb_pkg.sv ====
`default_nettype none
package dtb_pkg;
  // ****************************************
  // Word, address and block geometry
  // ****************************************
  localparam int DTB_WORD_W = 40;
  localparam int DTB_ADDR_W = 12;
  localparam int DTB_TRACK_W = 8;
  localparam int DTB_OP_W = 8;
  localparam int DTB_BLOCK_WORDS = 50;
  localparam int DTB_TETRAD_W = 4;
  localparam int DTB_TETRADS = 10;
  localparam int DTB_CNT_W = 6;
  localparam int DTB_TCNT_W = 4;

  // ****************************************
  // Order word field positions (bigit 0 is the MSB)
  // ****************************************
  localparam int DTB_OP_LSB = 32;
  localparam int DTB_ADDR_LSB = 20;
  localparam int DTB_TRACK_LSB = 12;
  localparam int DTB_JUMP_LSB = 0;
  localparam int DTB_SUM_BIT = 11;
  localparam logic [DTB_OP_W-1:0] DTB_OP_TO_DRUM = 8'hBD;
  localparam logic [DTB_OP_W-1:0] DTB_OP_FROM_DRUM = 8'hBC;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [DTB_WORD_W-1:0] DTB_ACC_RST = 40'h00000_00000;
  localparam logic [DTB_ADDR_W-1:0] DTB_CC_RST = 12'h000;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    DTB_S_IDLE = 3'h0,
    DTB_S_MRD = 3'h1,
    DTB_S_DOUT = 3'h2,
    DTB_S_DIN = 3'h3,
    DTB_S_MWR = 3'h4,
    DTB_S_TAPE = 3'h5,
    DTB_S_DONE = 3'h6
  } dtb_state_t;

  typedef enum logic [1:0] {
    DTB_M_TO_DRUM = 2'h0,
    DTB_M_FROM_DRUM = 2'h1,
    DTB_M_LOAD = 2'h2,
    DTB_M_READ = 2'h3
  } dtb_mode_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [DTB_ADDR_W-1:0] addr;
    logic [DTB_WORD_W-1:0] wdata;
  } dtb_mem_req_t;

  typedef struct packed {
    logic strobe;
    logic rdata;
  } dtb_drum_in_t;

  typedef struct packed {
    logic strobe;
    logic space;
    logic [DTB_TETRAD_W-1:0] tetrad;
  } dtb_tape_in_t;

  // ****************************************
  // Order field extraction
  // ****************************************
  function automatic logic [DTB_OP_W-1:0] dtb_op_of(input logic [DTB_WORD_W-1:0] w);
    return w[DTB_OP_LSB +: DTB_OP_W];
  endfunction

  function automatic logic [DTB_ADDR_W-1:0] dtb_addr_of(input logic [DTB_WORD_W-1:0] w);
    return w[DTB_ADDR_LSB +: DTB_ADDR_W];
  endfunction

  function automatic logic [DTB_TRACK_W-1:0] dtb_track_of(input logic [DTB_WORD_W-1:0] w);
    return w[DTB_TRACK_LSB +: DTB_TRACK_W];
  endfunction

  function automatic logic [DTB_ADDR_W-1:0] dtb_jump_of(input logic [DTB_WORD_W-1:0] w);
    return w[DTB_JUMP_LSB +: DTB_ADDR_W];
  endfunction
endpackage
`default_nettype wire

// ==== hw/dtb_serializer.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Word serializer: parallel load, serial shift MSB first
// ****************************************
module dtb_serializer
  import dtb_pkg::*;
#(
  parameter int WORD_W = DTB_WORD_W
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic load_i,
  input wire logic [WORD_W-1:0] data_i,
  input wire logic shift_i,
  input wire logic bit_i,
  output logic [WORD_W-1:0] word_o,
  output logic msb_o
);
  logic [WORD_W-1:0] word_ff;

  // Parallel load wins over a shift in the same cycle
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      word_ff <= '0;
    end else if (load_i) begin
      word_ff <= data_i;
    end else if (shift_i) begin
      word_ff <= {word_ff[WORD_W-2:0], bit_i};
    end
  end

  assign word_o = word_ff;
  assign msb_o = word_ff[WORD_W-1]; // Bit currently presented to the drum
endmodule
`default_nettype wire

// ==== hw/dtb_transfer.sv ====
`timescale 1ns/1ps
`default_nettype none
// Operation
// - To-drum order reads 50 memory words from order address field.
// - To-drum block is written onto the track named in the order.
// - On completion control counter takes jump field; fetch left instruction there.
// - From-drum order stores 50 track words at consecutive memory locations.
// - Serializer loads words in parallel, shifts serially; reverse for input.
// - Control counter steps per word, ends holding address of 50th word.
// - Address plus 800 hex: store at base and sum words into accumulator.
// - Accumulator never cleared; block sum adds onto previous contents.
// - Tape characters are four-bit groups, hole is one, blank zero.
// - Initial load from preset counter assembles ten-tetrad words.
// - Word-ending space writes the word at counter, then counter increments.
// - Two spaces end loading; counter returns to initial address.
// - Each tetrad shifts the input shift register four places.
// - Initial load adds every word into the accumulator.
// - Single read order puts next tape word at its own address.
// - Memory address comes from order register or control counter.
module dtb_transfer
  import dtb_pkg::*;
#(
  parameter int BLOCK_WORDS = DTB_BLOCK_WORDS
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic order_valid_i,
  input wire logic [DTB_WORD_W-1:0] order_i,
  input wire logic load_start_i,
  input wire logic [DTB_ADDR_W-1:0] load_addr_i,
  input wire logic read_start_i,
  input wire logic [DTB_ADDR_W-1:0] read_addr_i,
  output dtb_mem_req_t mem_o,
  input wire logic mem_grant_i,
  input wire logic [DTB_WORD_W-1:0] mem_rdata_i,
  input wire dtb_drum_in_t drum_i,
  output logic [DTB_TRACK_W-1:0] drum_track_o,
  output logic drum_write_o,
  output logic drum_read_o,
  output logic drum_wdata_o,
  input wire dtb_tape_in_t tape_i,
  output logic tape_rdy_o,
  output logic [DTB_WORD_W-1:0] acc_o,
  output logic [DTB_ADDR_W-1:0] cc_o,
  output logic busy_o,
  output logic done_o,
  output logic fetch_o
);
  localparam logic [DTB_CNT_W-1:0] LAST_WORD = DTB_CNT_W'(BLOCK_WORDS - 1);
  localparam logic [DTB_CNT_W-1:0] LAST_BIT = DTB_CNT_W'(DTB_WORD_W - 1);
  localparam logic [DTB_TCNT_W-1:0] FULL_TCNT = DTB_TCNT_W'(DTB_TETRADS);
  localparam int PIN_W = $bits(dtb_drum_in_t) + $bits(dtb_tape_in_t);

  dtb_state_t state_ff;
  dtb_mode_t mode_ff;
  dtb_mem_req_t mem_ff;
  logic [DTB_ADDR_W-1:0] cc_ff, init_ff, jump_ff, rd_addr_ff;
  logic [DTB_TRACK_W-1:0] track_ff;
  logic [DTB_CNT_W-1:0] wcnt_ff, bcnt_ff;
  logic [DTB_TCNT_W-1:0] tcnt_ff;
  logic [DTB_WORD_W-1:0] isr_ff, acc_ff, ser_word;
  logic sum_ff, spc_ff, done_ff, fetch_ff;
  logic drum_write_ff, drum_read_ff, tape_rdy_ff, busy_ff;
  logic [PIN_W-1:0] pin_meta_ff, pin_sync_ff;
  logic [1:0] edge_ff;
  dtb_drum_in_t sync_drum;
  dtb_tape_in_t sync_tape;
  logic drum_ev, tape_ev, ser_load, ser_shift, grant;

  // ****************************************
  // Pin synchronisers and strobe edges
  // ****************************************
  // Two flops on every drum and tape pin before any logic looks at it
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
      edge_ff <= 2'h0;
    end else begin
      pin_meta_ff <= {drum_i, tape_i};
      pin_sync_ff <= pin_meta_ff;
      edge_ff <= {sync_drum.strobe, sync_tape.strobe};
    end
  end

  // Unpack synchronised pins and detect rising strobes
  assign sync_drum = dtb_drum_in_t'(pin_sync_ff[PIN_W-1 -: $bits(dtb_drum_in_t)]);
  assign sync_tape = dtb_tape_in_t'(pin_sync_ff[$bits(dtb_tape_in_t)-1:0]);
  assign drum_ev = sync_drum.strobe & ~edge_ff[1];
  assign tape_ev = sync_tape.strobe & ~edge_ff[0];
  assign grant = mem_ff.req & mem_grant_i;

  // ****************************************
  // Word serializer between memory and drum
  // ****************************************
  // Loaded on a read grant, shifted on each drum bit slot
  assign ser_load = (state_ff == DTB_S_MRD) && grant;
  assign ser_shift = drum_ev && (state_ff == DTB_S_DOUT || state_ff == DTB_S_DIN);

  dtb_serializer #(
    .WORD_W(DTB_WORD_W)
  ) u_ser (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .load_i(ser_load),
    .data_i(mem_rdata_i),
    .shift_i(ser_shift),
    .bit_i(sync_drum.rdata),
    .word_o(ser_word),
    .msb_o(drum_wdata_o)
  );

  // ****************************************
  // Transfer sequencer
  // ****************************************
  // Order decode, word and bit counting, memory requests
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_ff <= DTB_S_IDLE;
      mode_ff <= DTB_M_TO_DRUM;
      mem_ff <= '0;
      cc_ff <= DTB_CC_RST;
      init_ff <= DTB_CC_RST;
      jump_ff <= DTB_CC_RST;
      rd_addr_ff <= DTB_CC_RST;
      track_ff <= '0;
      wcnt_ff <= '0;
      bcnt_ff <= '0;
      tcnt_ff <= '0;
      isr_ff <= '0;
      sum_ff <= 1'b0;
      spc_ff <= 1'b0;
      done_ff <= 1'b0;
      fetch_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      fetch_ff <= 1'b0;
      case (state_ff)
        DTB_S_IDLE: begin
          wcnt_ff <= '0;
          bcnt_ff <= '0;
          tcnt_ff <= '0;
          spc_ff <= 1'b0;
          if (order_valid_i && dtb_op_of(order_i) == DTB_OP_TO_DRUM) begin
            mode_ff <= DTB_M_TO_DRUM;
            sum_ff <= 1'b0;
            cc_ff <= dtb_addr_of(order_i);
            track_ff <= dtb_track_of(order_i);
            jump_ff <= dtb_jump_of(order_i);
            mem_ff <= '{req: 1'b1, we: 1'b0, addr: dtb_addr_of(order_i), wdata: '0};
            state_ff <= DTB_S_MRD;
          end else if (order_valid_i && dtb_op_of(order_i) == DTB_OP_FROM_DRUM) begin
            mode_ff <= DTB_M_FROM_DRUM;
            sum_ff <= order_i[DTB_ADDR_LSB + DTB_SUM_BIT];
            cc_ff <= dtb_addr_of(order_i) & ~(DTB_ADDR_W'(1) << DTB_SUM_BIT);
            track_ff <= dtb_track_of(order_i);
            jump_ff <= dtb_jump_of(order_i);
            state_ff <= DTB_S_DIN;
          end else if (load_start_i) begin
            mode_ff <= DTB_M_LOAD;
            cc_ff <= load_addr_i;
            init_ff <= load_addr_i;
            isr_ff <= '0;
            state_ff <= DTB_S_TAPE;
          end else if (read_start_i) begin
            mode_ff <= DTB_M_READ;
            rd_addr_ff <= read_addr_i;
            isr_ff <= '0;
            state_ff <= DTB_S_TAPE;
          end
        end
        DTB_S_MRD: begin
          // Word is taken into the serializer on the grant
          if (grant) begin
            mem_ff.req <= 1'b0;
            bcnt_ff <= '0;
            state_ff <= DTB_S_DOUT;
          end
        end
        DTB_S_DOUT: begin
          if (drum_ev) begin
            bcnt_ff <= bcnt_ff + DTB_CNT_W'(1);
            if (bcnt_ff == LAST_BIT) begin
              if (wcnt_ff == LAST_WORD) begin
                state_ff <= DTB_S_DONE;
              end else begin
                wcnt_ff <= wcnt_ff + DTB_CNT_W'(1);
                cc_ff <= cc_ff + DTB_ADDR_W'(1);
                mem_ff <= '{req: 1'b1, we: 1'b0, addr: cc_ff + DTB_ADDR_W'(1), wdata: '0};
                state_ff <= DTB_S_MRD;
              end
            end
          end
        end
        DTB_S_DIN: begin
          // Last bit completes the word; write it in parallel
          if (drum_ev) begin
            bcnt_ff <= bcnt_ff + DTB_CNT_W'(1);
            if (bcnt_ff == LAST_BIT) begin
              mem_ff <= '{req: 1'b1, we: 1'b1, addr: cc_ff,
                          wdata: {ser_word[DTB_WORD_W-2:0], sync_drum.rdata}};
              state_ff <= DTB_S_MWR;
            end
          end
        end
        DTB_S_MWR: begin
          if (grant) begin
            mem_ff.req <= 1'b0;
            bcnt_ff <= '0;
            case (mode_ff)
              DTB_M_FROM_DRUM: begin
                if (wcnt_ff == LAST_WORD) begin
                  state_ff <= DTB_S_DONE;
                end else begin
                  wcnt_ff <= wcnt_ff + DTB_CNT_W'(1);
                  cc_ff <= cc_ff + DTB_ADDR_W'(1);
                  state_ff <= DTB_S_DIN;
                end
              end
              DTB_M_LOAD: begin
                cc_ff <= cc_ff + DTB_ADDR_W'(1);
                spc_ff <= 1'b1;
                state_ff <= DTB_S_TAPE;
              end
              default: begin
                state_ff <= DTB_S_DONE;
              end
            endcase
          end
        end
        DTB_S_TAPE: begin
          if (tape_ev && !sync_tape.space) begin
            // Hole reads as one; four places per tetrad
            isr_ff <= {isr_ff[DTB_WORD_W-DTB_TETRAD_W-1:0], sync_tape.tetrad};
            if (tcnt_ff != FULL_TCNT) begin
              tcnt_ff <= tcnt_ff + DTB_TCNT_W'(1);
            end
            spc_ff <= 1'b0;
          end else if (tape_ev && tcnt_ff != '0) begin
            // Space ends the word: write at counter or order address
            mem_ff <= '{req: 1'b1, we: 1'b1,
                        addr: (mode_ff == DTB_M_READ) ? rd_addr_ff : cc_ff,
                        wdata: isr_ff};
            isr_ff <= '0;
            tcnt_ff <= '0;
            state_ff <= DTB_S_MWR;
          end else if (tape_ev && spc_ff && mode_ff == DTB_M_LOAD) begin
            cc_ff <= init_ff;
            state_ff <= DTB_S_DONE;
          end
        end
        DTB_S_DONE: begin
          if (mode_ff == DTB_M_TO_DRUM || mode_ff == DTB_M_FROM_DRUM) begin
            cc_ff <= jump_ff;
          end
          done_ff <= 1'b1;
          fetch_ff <= (mode_ff != DTB_M_READ);
          state_ff <= DTB_S_IDLE;
        end
        default: begin
          state_ff <= DTB_S_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Accumulator checksum
  // ****************************************
  // Summed on granted initial-load writes and on from-drum writes with the sum bit set; never cleared by a transfer
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      acc_ff <= DTB_ACC_RST;
    end else if (state_ff == DTB_S_MWR && grant &&
                 ((mode_ff == DTB_M_FROM_DRUM && sum_ff) || mode_ff == DTB_M_LOAD)) begin
      acc_ff <= acc_ff + mem_ff.wdata;
    end
  end

  // ****************************************
  // Status outputs
  // ****************************************
  // Link readiness levels, one cycle behind the state
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      drum_write_ff <= 1'b0;
      drum_read_ff <= 1'b0;
      tape_rdy_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      drum_write_ff <= (state_ff == DTB_S_DOUT);
      drum_read_ff <= (state_ff == DTB_S_DIN);
      tape_rdy_ff <= (state_ff == DTB_S_TAPE);
      busy_ff <= (state_ff != DTB_S_IDLE);
    end
  end

  assign mem_o = mem_ff;
  assign drum_track_o = track_ff;
  assign drum_write_o = drum_write_ff;
  assign drum_read_o = drum_read_ff;
  assign tape_rdy_o = tape_rdy_ff;
  assign acc_o = acc_ff;
  assign cc_o = cc_ff;
  assign busy_o = busy_ff;
  assign done_o = done_ff;
  assign fetch_o = fetch_ff;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  bd_start_a: assert property (state_ff == DTB_S_IDLE && order_valid_i &&
      dtb_op_of(order_i) == DTB_OP_TO_DRUM |=> mem_ff.req && !mem_ff.we &&
      mem_ff.addr == $past(dtb_addr_of(order_i)) && drum_track_o == $past(dtb_track_of(order_i)))
    else $error("to-drum order start address or track wrong");
  drum_track_a: assert property (drum_write_o |-> $stable(drum_track_o))
    else $error("track changed during drum write");
  jump_load_a: assert property (state_ff == DTB_S_DONE && mode_ff != DTB_M_READ
      && mode_ff != DTB_M_LOAD |=> cc_o == $past(jump_ff) && fetch_o && done_o)
    else $error("completion did not load jump address");
  ser_load_a: assert property (ser_load |=> ser_word == $past(mem_rdata_i)
      ##1 drum_wdata_o == $past(mem_rdata_i[DTB_WORD_W-1], 2))
    else $error("serializer did not take memory word");
  cc_step_a: assert property (state_ff == DTB_S_MWR && grant && mode_ff == DTB_M_FROM_DRUM
      && wcnt_ff != LAST_WORD |=> cc_ff == $past(cc_ff) + DTB_ADDR_W'(1))
    else $error("control counter did not step");
  sum_add_a: assert property (state_ff == DTB_S_MWR && grant && mode_ff == DTB_M_FROM_DRUM
      && sum_ff |=> acc_o == $past(acc_ff) + $past(mem_ff.wdata))
    else $error("checksum word not added");
  acc_hold_a: assert property (state_ff == DTB_S_IDLE ##1 state_ff == DTB_S_DIN
      |-> acc_ff == $past(acc_ff))
    else $error("accumulator disturbed at transfer start");
  tetrad_a: assert property (state_ff == DTB_S_TAPE && tape_ev && !sync_tape.space
      |=> isr_ff == {$past(isr_ff[DTB_WORD_W-DTB_TETRAD_W-1:0]), $past(sync_tape.tetrad)})
    else $error("tetrad not shifted four places");
  space_wr_a: assert property (state_ff == DTB_S_TAPE && mode_ff == DTB_M_LOAD && tape_ev
      && sync_tape.space && tcnt_ff != '0 |=> mem_ff.req && mem_ff.we && mem_ff.addr == $past(cc_ff))
    else $error("word end did not write at counter");
  end_load_a: assert property (state_ff == DTB_S_TAPE && mode_ff == DTB_M_LOAD && tape_ev
      && sync_tape.space && tcnt_ff == '0 && spc_ff |=> cc_ff == init_ff ##1 fetch_o)
    else $error("double space did not end loading");
  grant_hold_a: assert property (mem_ff.req && !mem_grant_i |=> mem_ff.req
      && $stable(mem_ff.addr) && $stable(mem_ff.wdata))
    else $error("memory request dropped before grant");

  to_drum_c: cover property (state_ff == DTB_S_DONE && mode_ff == DTB_M_TO_DRUM);
  sum_blk_c: cover property (state_ff == DTB_S_DONE && mode_ff == DTB_M_FROM_DRUM && sum_ff);
  load_end_c: cover property (fetch_o && $past(mode_ff) == DTB_M_LOAD);
  read_c: cover property (done_o && mode_ff == DTB_M_READ);
endmodule
`default_nettype wire

// ==== tb/dtb_far_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Far side: main memory and drum store
// ****************************************
module dtb_far_model
  import dtb_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire dtb_mem_req_t mem_i,
  input wire logic slow_i,
  output logic grant_o,
  output logic [DTB_WORD_W-1:0] rdata_o,
  input wire logic [DTB_TRACK_W-1:0] track_i,
  input wire logic write_rdy_i,
  input wire logic read_rdy_i,
  input wire logic wdata_i,
  input wire logic busy_i,
  output dtb_drum_in_t drum_o
);
  logic [DTB_WORD_W-1:0] mem [0:4095];
  logic [DTB_WORD_W-1:0] track_mem [0:255][0:DTB_BLOCK_WORDS-1];
  logic [7:0] pace_ff;
  int widx;
  int bidx;
  logic bitv;

  // Memory grants one action cycle per request, slowed when asked
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      grant_o <= 1'b0;
      pace_ff <= 8'h00;
    end else begin
      pace_ff <= pace_ff + 8'h01;
      grant_o <= mem_i.req && !grant_o && (!slow_i || pace_ff[2:0] == 3'h0);
      if (grant_o && mem_i.req && mem_i.we) begin
        mem[mem_i.addr] <= mem_i.wdata;
      end
    end
  end

  // Read data is valid only while granted, churns otherwise
  assign rdata_o = grant_o ? mem[mem_i.addr] : {5{pace_ff}};

  initial drum_o = '0;

  // Drum head: one bit slot per strobe, only while the device is ready
  always begin
    @(posedge clk_i);
    if (!busy_i) begin
      widx = 0;
      bidx = 0;
    end else if (write_rdy_i || read_rdy_i) begin
      bitv = read_rdy_i ? track_mem[track_i][widx][DTB_WORD_W-1-bidx] : wdata_i;
      if (write_rdy_i) begin
        track_mem[track_i][widx][DTB_WORD_W-1-bidx] = wdata_i;
      end
      drum_o <= '{strobe: 1'b1, rdata: bitv};
      repeat (4) @(posedge clk_i);
      drum_o <= '{strobe: 1'b0, rdata: ~bitv};
      repeat (6) @(posedge clk_i);
      bidx = bidx + 1;
      if (bidx == DTB_WORD_W) begin
        bidx = 0;
        widx = (widx + 1) % DTB_BLOCK_WORDS;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/drum_and_tape_block_transfer_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module drum_and_tape_block_transfer_test
  import dtb_pkg::*;
;
  logic clk, reset_n, order_valid, load_start, read_start, slow, grant;
  logic [DTB_WORD_W-1:0] order, rdata, acc;
  logic [DTB_ADDR_W-1:0] load_addr, read_addr, cc;
  dtb_mem_req_t mem;
  dtb_drum_in_t drum_in;
  dtb_tape_in_t tape;
  logic [DTB_TRACK_W-1:0] track;
  logic dwrite, dread, dwdata, tape_rdy, busy, done, fetch;
  logic [31:0] seed = 32'h0000_0003;
  int miscompares = 0;
  int comparisons = 0;
  int done_cnt = 0;
  int fetch_cnt = 0;

  // ****************************************
  // Design, far side and clock
  // ****************************************
  dtb_transfer i_dtb_transfer (.clk_i(clk), .reset_n_i(reset_n), .order_valid_i(order_valid),
    .order_i(order), .load_start_i(load_start), .load_addr_i(load_addr),
    .read_start_i(read_start), .read_addr_i(read_addr), .mem_o(mem), .mem_grant_i(grant),
    .mem_rdata_i(rdata), .drum_i(drum_in), .drum_track_o(track), .drum_write_o(dwrite),
    .drum_read_o(dread), .drum_wdata_o(dwdata), .tape_i(tape), .tape_rdy_o(tape_rdy),
    .acc_o(acc), .cc_o(cc), .busy_o(busy), .done_o(done), .fetch_o(fetch));
  dtb_far_model i_dtb_far_model (.clk_i(clk), .reset_n_i(reset_n), .mem_i(mem), .slow_i(slow),
    .grant_o(grant), .rdata_o(rdata), .track_i(track), .write_rdy_i(dwrite),
    .read_rdy_i(dread), .wdata_i(dwdata), .busy_i(busy), .drum_o(drum_in));

  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  // Count completion and fetch pulses
  always @(posedge clk) begin
    if (done === 1'b1) done_cnt++;
    if (fetch === 1'b1) fetch_cnt++;
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // First tetrad ends up most significant
  function automatic logic [39:0] shift_in(input logic [39:0] w, input logic [3:0] t);
    return {w[35:0], t};
  endfunction

  task automatic rnd(output logic [39:0] v);
    for (int k = 0; k < 40; k++) begin
      seed = lfsr(seed);
      v[k] = seed[0];
    end
  endtask

  task automatic wrap_up();
    if (miscompares == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic fail(input string m);
    miscompares++;
    $display("CHECK FAILED at %0t: %s", $time, m);
  endtask

  task automatic cmp(input logic [39:0] got, input logic [39:0] exp, input string m);
    comparisons++;
    if (got !== exp) fail(m);
  endtask

  task automatic wait_done(input int target);
    int n;
    for (n = 0; n < 30000 && done_cnt < target; n++) @(posedge clk);
    if (done_cnt < target) begin
      fail("no completion");
      wrap_up();
    end
  endtask

  // Reader: one character per strobe, tetrad released to its inverse
  task automatic tape_char(input logic sp, input logic [3:0] t);
    int n;
    for (n = 0; n < 200 && tape_rdy !== 1'b1; n++) @(posedge clk);
    if (tape_rdy !== 1'b1) begin
      fail("reader never ready");
      wrap_up();
    end
    tape <= '{strobe: 1'b1, space: sp, tetrad: t};
    repeat (5) @(posedge clk);
    tape <= '{strobe: 1'b0, space: 1'b0, tetrad: ~t};
    repeat (5) @(posedge clk);
  endtask

  // Initial load (load=1) or single read of one word
  task automatic run_tape(input logic load, input logic [11:0] a, input int nw);
    logic [39:0] w [4];
    logic [39:0] v, exp_acc;
    int d0, f0;
    exp_acc = acc;
    d0 = done_cnt;
    f0 = fetch_cnt;
    slow <= seed[1];
    load_start <= load;
    load_addr <= a;
    read_start <= !load;
    read_addr <= a;
    @(posedge clk);
    load_start <= 1'b0;
    read_start <= 1'b0;
    if (load) tape_char(1'b1, 4'h0);
    for (int i = 0; i < nw; i++) begin
      w[i] = '0;
      for (int k = 0; k < ((i == 1) ? 11 : 10); k++) begin
        rnd(v);
        w[i] = shift_in(w[i], v[3:0]);
        tape_char(1'b0, v[3:0]);
      end
      tape_char(1'b1, 4'h0);
      if (load) exp_acc = exp_acc + w[i];
    end
    if (load) tape_char(1'b1, 4'h0);
    wait_done(d0 + 1);
    for (int i = 0; i < nw; i++) cmp(i_dtb_far_model.mem[a + i], w[i], "tape word");
    cmp(acc, exp_acc, "tape sum");
    if (load) cmp(40'(cc), 40'(a), "counter after load");
    cmp(40'(fetch_cnt - f0), 40'(load), "fetch pulses");
  endtask

  // Drum order: op is BD or BC, flag asks for the hardware sum
  task automatic run_drum(input logic [7:0] op, input logic flag);
    logic [39:0] v, sum, exp_acc, tsum;
    logic [11:0] a, j;
    logic [7:0] tr;
    int d0, f0;
    rnd(v);
    a = {2'h0, v[9:0]};
    tr = v[19:12];
    j = v[31:20];
    sum = '0;
    tsum = '0;
    for (int i = 0; i < DTB_BLOCK_WORDS; i++) begin
      rnd(v);
      if (op == DTB_OP_TO_DRUM) i_dtb_far_model.mem[a + i] = v;
      else i_dtb_far_model.track_mem[tr][i] = v;
      sum = sum + v;
    end
    exp_acc = flag ? acc + sum : acc;
    d0 = done_cnt;
    f0 = fetch_cnt;
    slow <= seed[2];
    order_valid <= 1'b1;
    order <= {op, flag, a[10:0], tr, j};
    @(posedge clk);
    order_valid <= 1'b0;
    wait_done(d0 + 1);
    for (int i = 0; i < DTB_BLOCK_WORDS; i++) begin
      cmp(i_dtb_far_model.track_mem[tr][i], i_dtb_far_model.mem[a + i], "drum block");
      tsum = tsum + i_dtb_far_model.track_mem[tr][i];
    end
    // Software forms the to-drum checksum itself from the recorded track
    if (op == DTB_OP_TO_DRUM) cmp(tsum, sum, "software block sum");
    cmp(40'(cc), 40'(j), "counter after drum order");
    cmp(40'(fetch_cnt - f0), 40'd1, "fetch after drum order");
    cmp(acc, exp_acc, "drum sum");
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    reset_n = 1'b0;
    order_valid = 1'b0;
    order = '0;
    load_start = 1'b0;
    load_addr = '0;
    read_start = 1'b0;
    read_addr = '0;
    slow = 1'b0;
    tape = '0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    cmp(acc, DTB_ACC_RST, "accumulator reset");
    cmp(40'(cc), 40'(DTB_CC_RST), "counter reset");
    cmp(40'(busy), 40'd0, "busy reset");
    run_tape(1'b1, 12'h0F0, 3);
    run_drum(DTB_OP_TO_DRUM, 1'b0);
    run_drum(DTB_OP_FROM_DRUM, 1'b0);
    run_drum(DTB_OP_FROM_DRUM, 1'b1);
    run_tape(1'b0, 12'h5A3, 1);
    wrap_up();
  end
endmodule
`default_nettype wire
